// ---- rtl/ordinary_space_bus_controller.sv ----
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ordinary_space_bus_controller
   import osbc_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   // Mode
   input wire logic i_rom_present,
   // AXI4-Lite slave
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Internal masters
   input wire logic i_cpu_req,
   input wire logic i_dma_req,
   input wire logic i_dma_single,
   input wire logic i_req_write,
   input wire logic i_req_dram,
   input wire logic [1:0] i_req_space,
   input wire logic [15:0] i_req_wdata,
   output logic o_cpu_done,
   output logic o_dma_done,
   output logic [15:0] o_rd_data,
   // External memory pins
   output logic [3:0] o_space_select_n,
   output logic o_read_strobe_n,
   output logic o_write_strobe_n,
   output logic [15:0] o_data_out,
   output logic o_data_oe,
   input wire logic [15:0] i_data_in,
   input wire logic i_wait_n,
   // External bus master
   input wire logic i_bus_request_in_n,
   output logic o_bus_grant_n,
   // Flash emulation
   output logic o_flash_protect,
   output logic o_emu_active,
   output logic [1:0] o_emu_area
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_GAP = 3'b001,
      ST_LEAD = 3'b010,
      ST_T1 = 3'b011,
      ST_TW = 3'b100,
      ST_T2 = 3'b101,
      ST_TRAIL = 3'b110,
      ST_RELEASED = 3'b111
   } bus_state_e;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] space_stall_cfg;
   logic [15:0] bus_gap_cfg;
   logic [3:0] dma_single_stall_cfg;
   logic [2:0] flash_emu_area_sel;
   logic dram_read_gap;
   bus_state_e state;
   logic [3:0] wait_cnt;
   logic [1:0] gap_cnt;
   logic [1:0] idle_seen;
   logic last_read;
   logic last_dram;
   logic last_valid;
   logic [1:0] last_space;
   logic cur_write;
   logic cur_dram;
   logic cur_dma;
   logic cur_ext_wait;
   logic cur_stretch;
   logic [1:0] cur_space;
   logic [1:0] wait_sync;
   logic [1:0] bus_request_in_sync;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   logic do_write;
   assign o_awready = !aw_held && !o_bvalid;
   assign o_wready = !w_held && !o_bvalid;
   assign o_arready = !o_rvalid;
   assign do_write = aw_held && w_held && !o_bvalid;

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else if (i_clk_en) begin
         if (i_awvalid && o_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= reg_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic reg_known(input logic [7:0] a);
      reg_known = a == OFS_SPACE_STALL || a == OFS_BUS_GAP || a == OFS_DMA_STALL
         || a == OFS_EMU_SEL || a == OFS_DRAM_CTRL || a == OFS_STATUS;
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         space_stall_cfg <= RST_SPACE_STALL;
         bus_gap_cfg <= RST_BUS_GAP;
         dma_single_stall_cfg <= RST_DMA_STALL[3:0];
         flash_emu_area_sel <= RST_EMU_SEL[2:0];
         dram_read_gap <= RST_DRAM_CTRL[0];
      end else if (i_clk_en && do_write) begin
         unique case (aw_addr)
            OFS_SPACE_STALL: space_stall_cfg <= merge16(space_stall_cfg, w_data, i_wstrb);
            OFS_BUS_GAP: bus_gap_cfg <= merge16(bus_gap_cfg, w_data, i_wstrb);
            OFS_DMA_STALL: if (i_wstrb[0]) dma_single_stall_cfg <= w_data[3:0];
            OFS_EMU_SEL: if (i_wstrb[0]) flash_emu_area_sel <= w_data[2:0];
            OFS_DRAM_CTRL: if (i_wstrb[0]) dram_read_gap <= w_data[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= RESP_OKAY;
      end else if (i_clk_en) begin
         if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp <= reg_known(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (i_araddr)
               OFS_SPACE_STALL: o_rdata <= {16'h0000, space_stall_cfg};
               OFS_BUS_GAP: o_rdata <= {16'h0000, bus_gap_cfg};
               // Upper bits read zero
               OFS_DMA_STALL: o_rdata <= {28'h000_0000, dma_single_stall_cfg};
               OFS_EMU_SEL: o_rdata <= {29'h0000_0000, flash_emu_area_sel};
               OFS_DRAM_CTRL: o_rdata <= {31'h0000_0000, dram_read_gap};
               OFS_STATUS: o_rdata <= {27'h000_0000, !o_bus_grant_n, 1'b0, state};
               default: o_rdata <= 32'h0000_0000;
            endcase
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Flash emulation
   // ----------------------------------------
   assign o_emu_active = flash_emu_area_sel[EMU_SUB_BIT] && i_rom_present;
   assign o_flash_protect = o_emu_active;
   assign o_emu_area = flash_emu_area_sel[1:0];

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         wait_sync <= 2'b11;
         bus_request_in_sync <= 2'b11;
      end else if (i_clk_en) begin
         wait_sync <= {wait_sync[0], i_wait_n};
         bus_request_in_sync <= {bus_request_in_sync[0], i_bus_request_in_n};
      end
   end

   logic ext_req;
   assign ext_req = !bus_request_in_sync[1];

   // ----------------------------------------
   // Access planning
   // ----------------------------------------
   logic any_req;
   logic pick_dma;
   logic [3:0] next_wait;
   logic [1:0] need_gap;
   logic [1:0] conflict_gap;
   logic [1:0] same_gap;
   logic conflict;
   logic same;

   // Held request is not retaken in its own done cycle
   assign any_req = (i_dma_req || i_cpu_req) && !o_cpu_done && !o_dma_done;
   assign pick_dma = i_dma_req;
   // DMA single-address count never touches per-space count
   assign next_wait = (pick_dma && i_dma_single) ? dma_single_stall_cfg
                    : space_stall_cfg[i_req_space*4 +: 4];
   assign same = last_valid && !last_dram && !i_req_dram && last_space == i_req_space;
   assign conflict = last_valid && last_read && (i_req_write || !same);
   // Gap field of the space just read
   assign conflict_gap = !conflict ? 2'd0 : last_dram ? {1'b0, dram_read_gap}
                       : bus_gap_cfg[GAP_FIELD_LSB + last_space*2 +: 2];
   assign same_gap = same ? {1'b0, bus_gap_cfg[SAME_GAP_LSB + last_space]} : 2'd0;
   always_comb begin
      // Larger of the two, not the sum
      need_gap = (conflict_gap > same_gap) ? conflict_gap : same_gap;
      if (idle_seen != 2'd0 && !conflict) begin
         need_gap = 2'd0;
      end else if (idle_seen >= need_gap) begin
         need_gap = 2'd0;
      end else begin
         need_gap = need_gap - idle_seen;
      end
   end

   // ----------------------------------------
   // Bus sequencer
   // ----------------------------------------
   logic wait_hold;
   // Wait pin looked at in the final wait state, one state before T2
   assign wait_hold = cur_ext_wait && wait_cnt == 4'd1 && !wait_sync[1];

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= ST_IDLE;
         wait_cnt <= 4'd0;
         gap_cnt <= 2'd0;
         idle_seen <= 2'd3;
         last_valid <= 1'b0;
         last_read <= 1'b0;
         last_dram <= 1'b0;
         last_space <= 2'd0;
         cur_write <= 1'b0;
         cur_dram <= 1'b0;
         cur_dma <= 1'b0;
         cur_ext_wait <= 1'b0;
         cur_stretch <= 1'b0;
         cur_space <= 2'd0;
      end else if (i_clk_en) begin
         unique case (state)
            ST_IDLE, ST_GAP: begin
               if (state == ST_GAP && gap_cnt != 2'd0) begin
                  gap_cnt <= gap_cnt - 2'd1;
               end else if (ext_req) begin
                  state <= ST_RELEASED;
               end else if (any_req && state == ST_IDLE && need_gap != 2'd0) begin
                  state <= ST_GAP;
                  gap_cnt <= need_gap - 2'd1;
               end else if (any_req) begin
                  cur_write <= i_req_write;
                  cur_dram <= i_req_dram;
                  cur_dma <= pick_dma;
                  cur_space <= i_req_space;
                  wait_cnt <= next_wait;
                  cur_ext_wait <= next_wait != 4'd0;
                  cur_stretch <= bus_gap_cfg[STRETCH_LSB + i_req_space];
                  state <= bus_gap_cfg[STRETCH_LSB + i_req_space] ? ST_LEAD : ST_T1;
               end else begin
                  state <= ST_IDLE;
               end
               if (!(any_req && state == ST_IDLE) && idle_seen != 2'd3) begin
                  idle_seen <= idle_seen + 2'd1;
               end
            end
            ST_LEAD: state <= ST_T1;
            ST_T1: state <= (wait_cnt != 4'd0) ? ST_TW : ST_T2;
            ST_TW: begin
               if (!wait_hold) begin
                  wait_cnt <= wait_cnt - 4'd1;
                  if (wait_cnt == 4'd1) begin
                     state <= ST_T2;
                  end
               end
            end
            ST_T2: begin
               state <= cur_stretch ? ST_TRAIL : ST_IDLE;
               last_valid <= 1'b1;
               last_read <= !cur_write;
               last_dram <= cur_dram;
               last_space <= cur_space;
               idle_seen <= 2'd0;
            end
            ST_TRAIL: state <= ST_IDLE;
            ST_RELEASED: begin
               if (!ext_req) begin
                  state <= ST_IDLE;
                  last_valid <= 1'b0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Pin and completion outputs
   // ----------------------------------------
   logic in_cycle;
   logic strobe_on;
   assign in_cycle = state == ST_LEAD || state == ST_T1 || state == ST_TW
                   || state == ST_T2 || state == ST_TRAIL;
   assign strobe_on = state == ST_T1 || state == ST_TW || state == ST_T2;

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_space_select_n <= 4'hF;
         o_read_strobe_n <= 1'b1;
         o_write_strobe_n <= 1'b1;
         o_data_out <= 16'h0000;
         o_data_oe <= 1'b0;
         o_bus_grant_n <= 1'b1;
         o_cpu_done <= 1'b0;
         o_dma_done <= 1'b0;
         o_rd_data <= 16'h0000;
      end else if (i_clk_en) begin
         o_space_select_n <= 4'hF;
         if (in_cycle && !cur_dram) begin
            o_space_select_n[cur_space] <= 1'b0;
         end
         o_read_strobe_n <= !(strobe_on && !cur_write);
         o_write_strobe_n <= !(strobe_on && cur_write);
         // Data held through the trailing state
         o_data_oe <= in_cycle && cur_write;
         if (state == ST_LEAD || state == ST_T1) begin
            o_data_out <= i_req_wdata;
         end
         o_bus_grant_n <= !(state == ST_RELEASED && ext_req);
         o_cpu_done <= state == ST_T2 && !cur_dma;
         o_dma_done <= state == ST_T2 && cur_dma;
         if (state == ST_T2 && !cur_write) begin
            o_rd_data <= i_data_in;
         end
      end
   end
endmodule

// ---- include/osbc_pkg.sv ----
// Function
// - DMA single wait field, zero disables external wait
// - DMA wait independent of per-space waits
// - DMA wait register resets 000F, upper zero
// - Emulation select plus area; protects flash
// - Select bit ignored without on-chip ROM
// - Emulation register resets zero, reserved bits zero
// - Unwaited ordinary cycle takes exactly two states
// - Wait input sampled one cycle before final
// - Stretch adds lead and trail chip-select states
// - Write data held through trailing state
// - Read-then-write or new-area read gets idles
// - Existing idles count toward programmed gap
// - Gap field chosen by space just read
// - Gap 0-3 for spaces, 0-1 for DRAM
// - Same-space back-to-back gets continuous idle
// - Read-then-write same space uses larger gap
// - Existing idles cancel continuous idle
// - Priority: external, then DMA, then CPU
// - Request input, release, then grant output
// - Gap field encodes 0-3, resets three
// - Continuous idle bit one cycle, resets one
package osbc_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_SPACE_STALL = 8'h00;
   localparam logic [7:0] OFS_BUS_GAP = 8'h04;
   localparam logic [7:0] OFS_DMA_STALL = 8'h08;
   localparam logic [7:0] OFS_EMU_SEL = 8'h0C;
   localparam logic [7:0] OFS_DRAM_CTRL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] RST_SPACE_STALL = 16'hFFFF;
   localparam logic [15:0] RST_BUS_GAP = 16'hFFFF;
   localparam logic [15:0] RST_DMA_STALL = 16'h000F;
   localparam logic [15:0] RST_EMU_SEL = 16'h0000;
   localparam logic [15:0] RST_DRAM_CTRL = 16'h0001;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int GAP_FIELD_LSB = 8;
   localparam int SAME_GAP_LSB = 4;
   localparam int STRETCH_LSB = 0;
   localparam int EMU_SUB_BIT = 2;
   localparam int DMA_STALL_W = 4;
   localparam int EMU_W = 3;
   // ----------------------------------------
   // Bus responses
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- verification/osbc_props.sv ----
`timescale 1ns/1ps
module osbc_props (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Watched inputs
   input wire logic i_rom_present,
   input wire logic i_bus_request_in_n,
   // Watched outputs
   input wire logic o_cpu_done,
   input wire logic o_dma_done,
   input wire logic [3:0] o_space_select_n,
   input wire logic o_read_strobe_n,
   input wire logic o_write_strobe_n,
   input wire logic o_data_oe,
   input wire logic o_bus_grant_n,
   input wire logic o_flash_protect,
   input wire logic o_emu_active
);
   // ----------------------------------------
   // Bus cycle, arbitration and emulation checks
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);
   sequence s_low2(sig);
      !sig ##1 !sig;
   endsequence
   sequence s_grant_back;
      ##[1:6] o_bus_grant_n;
   endsequence
   a_read_two_state: assert property ($fell(o_read_strobe_n) |-> s_low2(o_read_strobe_n))
      else $error("read strobe shorter than two states");
   a_write_two_state: assert property ($fell(o_write_strobe_n) |-> s_low2(o_write_strobe_n))
      else $error("write strobe shorter than two states");
   a_strobes_apart: assert property (!(!o_read_strobe_n && !o_write_strobe_n))
      else $error("read and write strobes together");
   a_strobe_in_select: assert property (!o_read_strobe_n || !o_write_strobe_n |-> !(&o_space_select_n))
      else $error("strobe outside select");
   a_trail_data_held: assert property ($rose(o_write_strobe_n) && !(&o_space_select_n) |-> o_data_oe)
      else $error("write data dropped in trailing state");
   a_grant_after_req: assert property ($fell(o_bus_grant_n) |-> !$past(i_bus_request_in_n, 2))
      else $error("grant without request");
   a_grant_bus_free: assert property (!o_bus_grant_n |-> &o_space_select_n && !o_data_oe)
      else $error("bus driven while granted");
   a_grant_withdrawn: assert property ($rose(i_bus_request_in_n) |-> s_grant_back)
      else $error("grant kept after request withdrawn");
   a_one_master: assert property (!(o_cpu_done && o_dma_done))
      else $error("two masters served at once");
   a_emu_needs_rom: assert property (!i_rom_present |-> !o_emu_active && !o_flash_protect)
      else $error("emulation active without on-chip rom");
   a_emu_protects: assert property (o_emu_active |-> o_flash_protect)
      else $error("flash unprotected during emulation");
endmodule

bind ordinary_space_bus_controller osbc_props u_osbc_props (
   .i_core_clk, .i_reset, .i_rom_present, .i_bus_request_in_n, .o_cpu_done, .o_dma_done,
   .o_space_select_n, .o_read_strobe_n, .o_write_strobe_n, .o_data_oe, .o_bus_grant_n,
   .o_flash_protect, .o_emu_active
);

// ---- verification/osbc_ext_mem.sv ----
`timescale 1ns/1ps
module osbc_ext_mem (
   // Clock
   input wire logic i_core_clk,
   // Memory pins
   input wire logic [3:0] i_space_select_n,
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   input wire logic [15:0] i_data_out,
   input wire logic i_data_oe,
   output logic [15:0] o_data_in,
   output logic o_wait_n,
   // External master
   input wire logic i_bus_grant_n,
   output logic o_bus_request_in_n,
   // Bench controls
   input wire logic [3:0] i_stall,
   input wire logic i_want_bus
);
   logic [15:0] mem [4];
   logic [15:0] junk = 16'h5A5A;
   logic [3:0] stall_cnt = 4'h0;
   logic [2:0] held = 3'h0;
   logic was_idle = 1'b1;
   logic sel;
   logic [1:0] idx;
   initial o_bus_request_in_n = 1'b1;
   assign sel = !(&i_space_select_n);
   assign idx = !i_space_select_n[0] ? 2'h0 : !i_space_select_n[1] ? 2'h1 :
                !i_space_select_n[2] ? 2'h2 : 2'h3;
   // Released bus shows a changing pattern, never the last word
   assign o_data_in = (sel && !i_read_strobe_n) ? mem[idx] : junk;
   assign o_wait_n = (stall_cnt == 4'h0);
   always @(posedge i_core_clk) begin
      junk <= ~junk ^ 16'h0001;
      was_idle <= !sel;
      if (sel && !i_write_strobe_n && i_data_oe) mem[idx] <= i_data_out;
      if (sel && was_idle) stall_cnt <= i_stall;
      else if (stall_cnt != 4'h0) stall_cnt <= stall_cnt - 4'h1;
      // Request held until the grant has stood a while
      if (i_want_bus) o_bus_request_in_n <= 1'b0;
      else if (!i_bus_grant_n && held == 3'h5) o_bus_request_in_n <= 1'b1;
      held <= i_bus_grant_n ? 3'h0 : held + 3'h1;
   end
endmodule

// ---- verification/ordinary_space_bus_controller_test.sv ----
`timescale 1ns/1ps
module ordinary_space_bus_controller_test
   import osbc_pkg::*;
;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_rom_present = 1'b1;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic i_cpu_req = 1'b0, i_dma_req = 1'b0, i_dma_single = 1'b0, i_req_write = 1'b0;
   logic i_req_dram = 1'b0, want_bus = 1'b0, saw_grant = 1'b0, clk_en = 1'b1;
   logic [1:0] i_req_space = 2'h0;
   logic [15:0] i_req_wdata = 16'h0000;
   logic [3:0] stall = 4'h0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cpu_done, o_dma_done;
   logic o_read_strobe_n, o_write_strobe_n, o_data_oe, i_wait_n, i_bus_request_in_n;
   logic o_bus_grant_n, o_flash_protect, o_emu_active;
   logic [1:0] o_bresp, o_rresp, o_emu_area;
   logic [31:0] o_rdata;
   logic [15:0] o_rd_data, o_data_out, i_data_in, shadow [4];
   logic [3:0] o_space_select_n;
   logic [33:0] exp_q [$];
   int len_q [$], gap_q [$];
   int errors = 0, cmp_count = 0, sel_len = 0, idle = 0, last_len = 0;
   logic [7:0] ofs [6] = '{OFS_SPACE_STALL, OFS_BUS_GAP, OFS_DMA_STALL, OFS_EMU_SEL,
                           OFS_DRAM_CTRL, 8'h20};
   logic [15:0] rst [6] = '{16'hFFFF, 16'hFFFF, 16'h000F, 16'h0000, 16'h0001, 16'h0000};

   always #10 i_core_clk = ~i_core_clk;

   ordinary_space_bus_controller u_ordinary_space_bus_controller (
      .i_core_clk, .i_reset, .i_clk_en(clk_en), .i_rom_present, .i_awaddr, .i_awvalid, .o_awready,
      .i_wdata, .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
      .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_cpu_req, .i_dma_req,
      .i_dma_single, .i_req_write, .i_req_dram, .i_req_space, .i_req_wdata, .o_cpu_done,
      .o_dma_done, .o_rd_data, .o_space_select_n, .o_read_strobe_n, .o_write_strobe_n,
      .o_data_out, .o_data_oe, .i_data_in, .i_wait_n, .i_bus_request_in_n, .o_bus_grant_n,
      .o_flash_protect, .o_emu_active, .o_emu_area
   );
   osbc_ext_mem u_osbc_ext_mem (
      .i_core_clk, .i_space_select_n(o_space_select_n), .i_read_strobe_n(o_read_strobe_n),
      .i_write_strobe_n(o_write_strobe_n), .i_data_out(o_data_out), .i_data_oe(o_data_oe),
      .o_data_in(i_data_in), .o_wait_n(i_wait_n), .i_bus_grant_n(o_bus_grant_n),
      .o_bus_request_in_n(i_bus_request_in_n), .i_stall(stall), .i_want_bus(want_bus)
   );

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task conclude;
      $display("comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge i_core_clk) begin
      if (o_rvalid && i_rready) chk({o_rresp, o_rdata} === exp_q.pop_front(), "register read");
      if ((o_cpu_done || o_dma_done) && !i_req_write)
         chk({18'h0_0000, o_rd_data} === exp_q.pop_front(), "memory read");
      if (o_bus_grant_n === 1'b0) saw_grant = 1'b1;
      if (!(&o_space_select_n)) begin
         if (sel_len == 0 && gap_q.size() > 0) chk(idle >= gap_q.pop_front(), "idle gap");
         sel_len++;
         idle = 0;
      end else begin
         if (sel_len > 0 && len_q.size() > 0 && len_q[0] > 0) chk(sel_len == len_q[0], "cycle length");
         if (sel_len > 0 && len_q.size() > 0) void'(len_q.pop_front());
         if (sel_len > 0) last_len = sel_len;
         sel_len = 0;
         idle++;
      end
   end

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok, w_ok;
      @(posedge i_core_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge i_core_clk);
         if (i_awvalid && o_awready) begin
            aw_ok = 1'b1;
            i_awvalid <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_ok = 1'b1;
            i_wvalid <= 1'b0;
         end
      end
      while (o_bvalid !== 1'b1) @(posedge i_core_clk);
      chk(o_bresp === r, "write response");
      i_bready <= 1'b0;
   endtask
   task axi_rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
      @(posedge i_core_clk);
      exp_q.push_back({r, 16'h0000, d});
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do @(posedge i_core_clk); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      do @(posedge i_core_clk); while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
   endtask
   task mem(input logic dma, single, wr, input logic [1:0] sp, input int len, gap);
      logic [15:0] d;
      d = 16'($urandom);
      if (wr) shadow[sp] = d;
      else exp_q.push_back({18'h0_0000, shadow[sp]});
      len_q.push_back(len);
      gap_q.push_back(gap);
      @(posedge i_core_clk);
      i_dma_req <= dma;
      i_cpu_req <= !dma;
      i_dma_single <= single;
      i_req_write <= wr;
      i_req_space <= sp;
      i_req_wdata <= d;
      do @(posedge i_core_clk); while (!(o_cpu_done || o_dma_done));
      i_cpu_req <= 1'b0;
      i_dma_req <= 1'b0;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'hbacf));
      repeat (6) @(posedge i_core_clk);
      i_reset <= 1'b0;
      foreach (ofs[i]) axi_rd(ofs[i], rst[i], (i == 5) ? RESP_SLVERR : RESP_OKAY);
      axi_wr(8'h20, 32'h0000_0001, RESP_SLVERR);
      axi_wr(OFS_DMA_STALL, 32'h0000_FFF5, RESP_OKAY);
      axi_rd(OFS_DMA_STALL, 16'h0005, RESP_OKAY);
      axi_wr(OFS_EMU_SEL, 32'h0000_0006, RESP_OKAY);
      @(posedge i_core_clk);
      chk(o_emu_active === 1'b1 && o_flash_protect === 1'b1 && o_emu_area === 2'h2, "emulation");
      i_rom_present <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      chk(o_emu_active === 1'b0 && o_flash_protect === 1'b0, "no rom mode");
      i_rom_present <= 1'b1;
      // Emulation select and area cleared right after the check
      axi_wr(OFS_EMU_SEL, 32'h0000_0000, RESP_OKAY);
      axi_wr(OFS_SPACE_STALL, 32'h0000_0000, RESP_OKAY);
      // Conflict gap of space s programmed as s, one same-space idle each
      axi_wr(OFS_BUS_GAP, 32'h0000_E4F0, RESP_OKAY);
      for (int s = 0; s < 4; s++) mem(1'b0, 1'b0, 1'b1, 2'(s), 2, 0);
      for (int s = 0; s < 4; s++) begin
         mem(1'b0, 1'b0, 1'b0, 2'(s), 2, (s == 0) ? 0 : s - 1);
         mem(1'b0, 1'b0, 1'b1, 2'(s), 2, (s > 1) ? s : 1);
         mem(1'b0, 1'b0, 1'b0, 2'(s), 2, 1);
      end
      axi_wr(OFS_BUS_GAP, 32'h0000_E4FF, RESP_OKAY);
      for (int s = 0; s < 4; s++) begin
         mem(1'b0, 1'b0, 1'b1, 2'(s), 4, 0);
         mem(1'b0, 1'b0, 1'b0, 2'(s), 4, 1);
      end
      axi_wr(OFS_BUS_GAP, 32'h0000_E4F0, RESP_OKAY);
      axi_wr(OFS_DMA_STALL, 32'h0000_0003, RESP_OKAY);
      mem(1'b1, 1'b1, 1'b0, 2'h0, 5, 0);
      mem(1'b0, 1'b0, 1'b0, 2'h0, 2, 0);
      mem(1'b1, 1'b0, 1'b0, 2'h1, 2, 0);
      axi_wr(OFS_DMA_STALL, 32'h0000_0000, RESP_OKAY);
      mem(1'b1, 1'b1, 1'b0, 2'h1, 2, 0);
      // Four waits cover the wait pin synchroniser
      axi_wr(OFS_SPACE_STALL, 32'h0000_0004, RESP_OKAY);
      stall <= 4'h6;
      mem(1'b0, 1'b0, 1'b0, 2'h0, 0, 0);
      repeat (3) @(posedge i_core_clk);
      chk(last_len > 6, "wait pin stretch");
      stall <= 4'h0;
      len_q.push_back(2);
      len_q.push_back(2);
      gap_q.push_back(0);
      gap_q.push_back(0);
      i_req_write <= 1'b1;
      i_cpu_req <= 1'b1;
      i_dma_req <= 1'b1;
      i_dma_single <= 1'b0;
      i_req_space <= 2'h1;
      clk_en <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      chk(&o_space_select_n, "clock enable freeze");
      clk_en <= 1'b1;
      do @(posedge i_core_clk); while (!(o_cpu_done || o_dma_done));
      chk(o_dma_done === 1'b1 && o_cpu_done === 1'b0, "priority");
      i_dma_req <= 1'b0;
      do @(posedge i_core_clk); while (o_cpu_done !== 1'b1);
      i_cpu_req <= 1'b0;
      fork
         mem(1'b0, 1'b0, 1'b1, 2'h2, 2, 0);
         begin
            repeat (2) @(posedge i_core_clk);
            want_bus <= 1'b1;
            @(posedge i_core_clk);
            want_bus <= 1'b0;
         end
      join
      repeat (20) @(posedge i_core_clk);
      chk(saw_grant === 1'b1 && o_bus_grant_n === 1'b1, "bus handover");
      conclude();
   end
   initial begin
      repeat (20000) @(posedge i_core_clk);
      errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
